// File: bench/rcd_dynamics_chk.sv
// Checker for the range controller dynamics block: bus answers, readback, path timing.
// Assumes it is bound to rcd_dynamics and sees only that module's ports.
`include "rcd_consts.svh"
module rcd_dynamics_chk (
  input wire logic                 clock_in,
  input wire logic                 rstn_in,
  input wire logic                 wb_cyc_in,
  input wire logic                 wb_stb_in,
  input wire logic                 wb_we_in,
  input wire logic [31:0]          wb_adr_in,
  input wire logic [3:0]           wb_sel_in,
  input wire logic [31:0]          wb_dat_in,
  input wire logic [31:0]          wb_dat_out,
  input wire logic                 wb_ack_out,
  input wire rcd_pkg::rcd_sample_t mic_sample_in,
  input wire logic                 mic_valid_in,
  input wire rcd_pkg::rcd_sample_t dac_sample_in,
  input wire logic                 dac_valid_in,
  input wire rcd_pkg::rcd_sample_t mic_sample_out,
  input wire logic                 mic_valid_out,
  input wire rcd_pkg::rcd_sample_t dac_sample_out,
  input wire logic                 dac_valid_out
);
  import rcd_pkg::*;
  localparam logic [31:0] MAIN_A = {22'h000000, `RCD_IDX_MAIN, 2'h0};
  localparam logic [31:0] TIM_A  = {22'h000000, `RCD_IDX_TIMING, 2'h0};
  localparam logic [31:0] STAT_A = {22'h000000, `RCD_IDX_STATUS, 2'h0};
  rcd_reg_t main_ff, nxt_main, tim_ff, nxt_tim;
  logic     wr_hit, rd_hit, mic_thru, dac_thru;

  // Byte lane merge used by the register mirror
  function automatic rcd_reg_t lanes(rcd_reg_t o, logic [31:0] d, logic [3:0] s);
    lanes = o;
    if (s[0]) lanes[7:0] = d[7:0];
    if (s[1]) lanes[15:8] = d[15:8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Mirror of the control words; a write lands only at its ack edge
  assign wr_hit   = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;
  assign rd_hit   = wb_ack_out && !wb_we_in;
  assign mic_thru = !main_ff[15] || main_ff[14];
  assign dac_thru = !main_ff[15] || !main_ff[14];
  always_comb begin
    nxt_main = (wr_hit && wb_adr_in == MAIN_A) ? lanes(main_ff, wb_dat_in, wb_sel_in) : main_ff;
    nxt_tim  = (wr_hit && wb_adr_in == TIM_A) ? lanes(tim_ff, wb_dat_in, wb_sel_in) : tim_ff;
  end
  // Register the mirror
  always_ff @(posedge clock_in) begin
    main_ff <= rstn_in ? nxt_main : `RCD_MAIN_RST;
    tim_ff  <= rstn_in ? nxt_tim : `RCD_TIMING_RST;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Properties; both paths bypass the gain when not the selected, enabled path
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  sequence s_mic_pass;
    mic_valid_in && mic_thru ##2 mic_thru;
  endsequence
  sequence s_dac_pass;
    dac_valid_in && dac_thru ##2 dac_thru;
  endsequence
  sequence s_mic_lat;
    ##1 !mic_valid_out ##1 mic_valid_out;
  endsequence

  chk_ack_follows_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  chk_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  chk_upper_read_zero: assert property (rd_hit |-> wb_dat_out[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_hole_read_zero: assert property (rd_hit && wb_adr_in != MAIN_A && wb_adr_in != TIM_A
      && wb_adr_in != STAT_A |-> wb_dat_out == 32'h00000000)
    else $error("unmapped read not zero");
  chk_main_read_back: assert property (
      rd_hit && wb_adr_in == MAIN_A |-> wb_dat_out[15:0] == main_ff)
    else $error("main control readback wrong");
  chk_timing_read_back: assert property (
      rd_hit && wb_adr_in == TIM_A |-> wb_dat_out[15:0] == tim_ff)
    else $error("timing control readback wrong");
  chk_mic_sample_latency: assert property (mic_valid_in |-> s_mic_lat)
    else $error("mic output strobe not two cycles after input");
  chk_dac_out_cause: assert property (dac_valid_out |-> $past(dac_valid_in, 2))
    else $error("dac output strobe without input");
  chk_mic_bypass_exact: assert property (
      s_mic_pass |-> mic_sample_out == $past(mic_sample_in, 2))
    else $error("mic bypass sample altered");
  chk_dac_bypass_exact: assert property (
      s_dac_pass |-> dac_sample_out == $past(dac_sample_in, 2))
    else $error("dac bypass sample altered");
endmodule

bind rcd_dynamics rcd_dynamics_chk rcd_dynamics_chk_i (
  .clock_in(clock_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .mic_sample_in(mic_sample_in),
  .mic_valid_in(mic_valid_in), .dac_sample_in(dac_sample_in), .dac_valid_in(dac_valid_in),
  .mic_sample_out(mic_sample_out), .mic_valid_out(mic_valid_out),
  .dac_sample_out(dac_sample_out), .dac_valid_out(dac_valid_out));

// File: bench/rcd_src_model.sv
// Sample source standing in for the microphone and playback streams.
// Assumes the block's clock; one sample every four cycles on both paths.
module rcd_src_model (
  input  wire logic            clock_in,
  input  wire logic            rstn_in,
  input  wire logic            loud_in,
  output rcd_pkg::rcd_sample_t mic_sample_out,
  output logic                 mic_valid_out,
  output rcd_pkg::rcd_sample_t dac_sample_out,
  output logic                 dac_valid_out
);
  import rcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt_ff, nxt_cnt;
  logic        nxt_valid;
  rcd_sample_t nxt_mic, nxt_dac;

  ////////////////////////////////////////////////////////////////////////////////
  // Loud is a full-swing square; quiet is a small ramp so each sample differs
  always_comb begin
    nxt_cnt   = cnt_ff + 8'h01;
    nxt_valid = cnt_ff[1:0] == 2'h3;
    nxt_mic   = ~mic_sample_out; // Line toggles between strobes, never holds
    nxt_dac   = ~dac_sample_out;
    if (nxt_valid) begin
      nxt_mic = loud_in ? (cnt_ff[2] ? 16'h7000 : 16'h9000) : {10'h000, cnt_ff[7:2]} - 16'h0020;
      nxt_dac = -nxt_mic;
    end
  end
  // Register the stream
  always_ff @(posedge clock_in) begin
    cnt_ff         <= rstn_in ? nxt_cnt : 8'h00;
    mic_valid_out  <= rstn_in && nxt_valid;
    dac_valid_out  <= rstn_in && nxt_valid;
    mic_sample_out <= rstn_in ? nxt_mic : 16'h0000;
    dac_sample_out <= rstn_in ? nxt_dac : 16'h0000;
  end
endmodule

// File: bench/test_rcd_dynamics.sv
// Testbench for the range controller dynamics block: registers, delays, gain slew.
// Assumes the checker is bound by its own file and the source model drives samples.
`include "rcd_consts.svh"
module test_rcd_dynamics;
  import rcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] MAIN_A = {22'h000000, `RCD_IDX_MAIN, 2'h0};
  localparam logic [31:0] TIM_A  = {22'h000000, `RCD_IDX_TIMING, 2'h0};
  localparam logic [31:0] STAT_A = {22'h000000, `RCD_IDX_STATUS, 2'h0};
  logic        clock_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        loud = 1'b0, chk_on = 1'b0, mic_vi, dac_vi, mic_vo, dac_vo, wb_ack;
  logic [31:0] adr = 32'h00000000, wdat = 32'h00000000, rdat, wb_dat;
  logic [3:0]  sel = 4'h0;
  logic [11:0] att1, att2;
  rcd_sample_t mic_si, dac_si, mic_so, dac_so, mic_h[64], dac_h[64];
  int          mic_n = 0, dac_n = 0, dm = 0, dd = 0, mismatches = 0, checked = 0, cycles = 0;
  logic [15:0] mode_v[5] = '{16'h8022, 16'h8002, 16'h8020, 16'hC022, 16'h0022};
  int          mode_m[5] = '{9, 5, 0, 0, 0};
  int          mode_d[5] = '{0, 0, 0, 9, 0};

  rcd_dynamics rcd_dynamics_i (.clock_in(clock_in), .rstn_in(rstn_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(wb_dat), .wb_ack_out(wb_ack), .mic_sample_in(mic_si), .mic_valid_in(mic_vi),
    .dac_sample_in(dac_si), .dac_valid_in(dac_vi), .mic_sample_out(mic_so),
    .mic_valid_out(mic_vo), .dac_sample_out(dac_so), .dac_valid_out(dac_vo));
  rcd_src_model rcd_src_model_i (.clock_in(clock_in), .rstn_in(rstn_in), .loud_in(loud),
    .mic_sample_out(mic_si), .mic_valid_out(mic_vi), .dac_sample_out(dac_si),
    .dac_valid_out(dac_vi));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks and the closing report
  task automatic cmp_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_smp(input string what, input rcd_sample_t exp, input rcd_sample_t got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic got);
    checked++;
    if (got !== 1'b1) begin
      mismatches++;
      $display("BAD %s expected 1 seen %b", what, got);
    end
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // One classic cycle; held until ack is sampled, read data taken at that edge
  task automatic wb_go(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'h3;
    do @(posedge clock_in); while (wb_ack !== 1'b1);
    rdat = wb_dat;
    cyc  <= 1'b0;
    stb  <= 1'b0;
  endtask

  // Clock and timeout; the ceiling is about 1.7 times the planned run
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      wrap_up();
    end
  end

  // Each delivered sample must equal the input from the chosen distance back
  always @(posedge clock_in) begin
    if (chk_on && mic_vo) cmp_smp("mic out", mic_h[(mic_n - 1 - dm) & 63], mic_so);
    if (chk_on && dac_vo) cmp_smp("dac out", dac_h[(dac_n - 1 - dd) & 63], dac_so);
    if (mic_vi) mic_h[mic_n++ & 63] = mic_si;
    if (dac_vi) dac_h[dac_n++ & 63] = dac_si;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    wb_go(1'b0, MAIN_A, 32'h00000000);
    cmp_reg("main reset", 16'h0026, rdat[15:0] & 16'hC026);
    wb_go(1'b0, TIM_A, 32'h00000000);
    cmp_reg("timing reset", 16'h3240, rdat[15:0] & 16'hFFF0);
    // Every attack, decay, threshold and fast rate code written and read back
    for (int i = 0; i < 10; i++) begin
      wb_go(1'b1, TIM_A, {16'h0000, 4'(i + 1), 4'(i % 9), 2'(i % 4), 2'(i % 3), 4'h0});
      wb_go(1'b0, TIM_A, 32'h00000000);
      cmp_reg("timing", {4'(i + 1), 4'(i % 9), 2'(i % 4), 2'(i % 3), 4'h0}, rdat[15:0]);
    end
    // Unmapped write is dropped and reads back zero
    wb_go(1'b1, 32'h000000B0, 32'h0000FFFF);
    wb_go(1'b0, 32'h000000B0, 32'h00000000);
    cmp_reg("hole", 16'h0000, rdat[15:0]);
    // Look-ahead delay per mode; the unselected path passes straight through
    for (int k = 0; k < 5; k++) begin
      wb_go(1'b1, MAIN_A, {16'h0000, mode_v[k]});
      dm <= mode_m[k];
      dd <= mode_d[k];
      repeat (60) @(posedge clock_in);
      chk_on <= 1'b1;
      repeat (40) @(posedge clock_in);
      chk_on <= 1'b0;
    end
    // Loud input lowers gain; quiet input raises it slowly, then fast with release on
    wb_go(1'b1, TIM_A, 32'h00001000);
    wb_go(1'b1, MAIN_A, 32'h00008020);
    loud <= 1'b1;
    repeat (1600) @(posedge clock_in);
    wb_go(1'b0, STAT_A, 32'h00000000);
    att1 = rdat[11:0];
    cmp_flag("attack lowers gain", att1 > 12'h000);
    loud <= 1'b0;
    repeat (800) @(posedge clock_in);
    wb_go(1'b0, STAT_A, 32'h00000000);
    att2 = rdat[11:0];
    cmp_flag("slow decay", att2 > att1 / 2);
    wb_go(1'b1, MAIN_A, 32'h00008024);
    // Averaged power needs several hundred samples to fall under the decaying peak by the crest ratio first
    repeat (20000) @(posedge clock_in);
    wb_go(1'b0, STAT_A, 32'h00000000);
    cmp_flag("fast release", rdat[11:0] < att2 / 4);
    wrap_up();
  end
endmodule

// File: design/rcd_delay_mem.sv
// Sixteen-entry sample store for the look-ahead delay line.
// Assumes one write per sample; read data is registered, one cycle late.
module rcd_delay_mem (
  input  wire logic                clock_in,
  input  wire logic                we_in,
  input  wire logic [3:0]          waddr_in,
  input  wire rcd_pkg::rcd_sample_t wdata_in,
  input  wire logic [3:0]          raddr_in,
  output rcd_pkg::rcd_sample_t     rdata_out
);
  import rcd_pkg::*;

  rcd_sample_t mem_ff [16];
  rcd_sample_t rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Storage needs no reset; stale words only matter for the first few samples
  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem_ff[waddr_in] <= wdata_in;
    end
    rdata_ff <= mem_ff[raddr_in];
  end

  assign rdata_out = rdata_ff;
endmodule

// File: design/rcd_dynamics.sv
// Dynamic range controller dynamics: gain slew, look-ahead guard, fast release.
// Assumes samples arrive from same-clock logic with one-cycle valid strobes
// spaced at least three cycles apart, and a classic Wishbone master.
`include "rcd_consts.svh"
module rcd_dynamics (
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  input  wire logic                 wb_cyc_in,
  input  wire logic                 wb_stb_in,
  input  wire logic                 wb_we_in,
  input  wire logic [31:0]          wb_adr_in,
  input  wire logic [3:0]           wb_sel_in,
  input  wire logic [31:0]          wb_dat_in,
  output logic [31:0]               wb_dat_out,
  output logic                      wb_ack_out,
  input  wire rcd_pkg::rcd_sample_t mic_sample_in,
  input  wire logic                 mic_valid_in,
  input  wire rcd_pkg::rcd_sample_t dac_sample_in,
  input  wire logic                 dac_valid_in,
  output rcd_pkg::rcd_sample_t      mic_sample_out,
  output logic                      mic_valid_out,
  output rcd_pkg::rcd_sample_t      dac_sample_out,
  output logic                      dac_valid_out
);
  import rcd_pkg::*;

  rcd_reg_t     main_ff, nxt_main, timing_ff, nxt_timing, status;
  logic         ack_ff, nxt_ack;
  logic [31:0]  rdat_ff, nxt_rdat;
  logic         wb_req, adr_ok;
  logic [7:0]   adr_idx;
  rcd_sample_t  mic_x1_ff, nxt_mic_x1, dac_x1_ff, nxt_dac_x1;
  logic         mic_v1_ff, nxt_mic_v1, dac_v1_ff, nxt_dac_v1;
  rcd_sample_t  mic_o_ff, nxt_mic_o, dac_o_ff, nxt_dac_o;
  logic         mic_vo_ff, nxt_mic_vo, dac_vo_ff, nxt_dac_vo;
  logic [3:0]   wp_ff, nxt_wp, dly, raddr;
  rcd_gain_t    gain_ff, nxt_gain, step, atk_step, dcy_step, fast_step, dn, up;
  logic         clip_ff, nxt_clip;
  logic         en, on_dac, guard, fast_en, sel_v, proc_v, clip_hit, loud, crest;
  rcd_sample_t  sel_x, x1, delayed, mem_q, y, det_x;
  logic         det_v;
  logic [15:0]  lin;
  logic [16:0]  ax;
  logic [32:0]  la;
  logic signed [32:0] prod;
  logic [3:0]   atk_code, dcy_code;
  rcd_slew_t    slew;

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, write lands with ack
  always_comb begin
    wb_req     = wb_cyc_in & wb_stb_in;
    adr_idx    = wb_adr_in[9:2];
    adr_ok     = (wb_adr_in[31:10] == 22'h000000) && (wb_adr_in[1:0] == 2'h0);
    nxt_ack    = wb_req & ~ack_ff;
    nxt_rdat   = rdat_ff;
    nxt_main   = main_ff;
    nxt_timing = timing_ff;
    status     = {loud, crest, clip_ff, en, gain_ff[25:14]};
    if (wb_req && !ack_ff && !wb_we_in) begin
      nxt_rdat = 32'h00000000; // Unmapped words read as zero
      if (adr_ok) begin
        case (adr_idx)
          `RCD_IDX_MAIN:   nxt_rdat = {16'h0000, main_ff};
          `RCD_IDX_TIMING: nxt_rdat = {16'h0000, timing_ff};
          `RCD_IDX_STATUS: nxt_rdat = {16'h0000, status};
          default:         nxt_rdat = 32'h00000000;
        endcase
      end
    end
    // Bits 16 and up carry nothing; those lanes are dropped
    if (wb_req && ack_ff && wb_we_in && adr_ok) begin
      if (adr_idx == `RCD_IDX_MAIN) begin
        if (wb_sel_in[0]) nxt_main[`RCD_LANE0] = wb_dat_in[`RCD_LANE0];
        if (wb_sel_in[1]) nxt_main[`RCD_LANE1] = wb_dat_in[`RCD_LANE1];
      end
      if (adr_idx == `RCD_IDX_TIMING) begin
        if (wb_sel_in[0]) nxt_timing[`RCD_LANE0] = wb_dat_in[`RCD_LANE0];
        if (wb_sel_in[1]) nxt_timing[`RCD_LANE1] = wb_dat_in[`RCD_LANE1];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      main_ff   <= `RCD_MAIN_RST;
      timing_ff <= `RCD_TIMING_RST;
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h00000000;
    end else begin
      main_ff   <= nxt_main;
      timing_ff <= nxt_timing;
      ack_ff    <= nxt_ack;
      rdat_ff   <= nxt_rdat;
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdat_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Path choice and delay line addressing
  always_comb begin
    en      = main_ff[`RCD_EN_BIT];
    on_dac  = main_ff[`RCD_PATH_BIT];
    guard   = main_ff[`RCD_CLIP_BIT];
    fast_en = main_ff[`RCD_QR_BIT];
    sel_v   = en & (on_dac ? dac_valid_in : mic_valid_in);
    sel_x   = on_dac ? dac_sample_in : mic_sample_in;
    dly     = main_ff[`RCD_FFDLY_BIT] ? `RCD_DLY_LONG : `RCD_DLY_SHORT;
    raddr   = 4'(wp_ff - dly);
    nxt_wp  = sel_v ? 4'(wp_ff + 4'h1) : wp_ff;
  end

  rcd_delay_mem u_delay (
    .clock_in  (clock_in),
    .we_in     (sel_v),
    .waddr_in  (wp_ff),
    .wdata_in  (sel_x),
    .raddr_in  (raddr),
    .rdata_out (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Gain law: attenuation in log units, 6dB per 2^24, linear form in Q1.15.
  // The fraction uses a straight-line approximation; error stays under 0.6dB.
  always_comb begin
    proc_v  = en & (on_dac ? dac_v1_ff : mic_v1_ff);
    x1      = on_dac ? dac_x1_ff : mic_x1_ff;
    delayed = guard ? mem_q : x1;
    lin     = (`RCD_UNITY - 16'(gain_ff[23:0] >> `RCD_FRAC_DROP)) >> gain_ff[25:24];
    prod    = $signed(delayed) * $signed({1'b0, lin});
    y       = 16'(prod >>> `RCD_Q_SHIFT);
    ax      = x1[15] ? 17'(-$signed({x1[15], x1})) : {1'b0, x1};
    la      = (33'(ax) * 33'(lin)) >> `RCD_Q_SHIFT;
    // Undelayed sample seen through the current gain warns of clipping early
    clip_hit = guard & (la > `RCD_CLIP_LEVEL);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Slew step selection; reserved codes clamp to the nearest legal one
  always_comb begin
    atk_code = timing_ff[`RCD_ATK_F];
    if (atk_code < `RCD_ATK_MIN) atk_code = `RCD_ATK_MIN;
    if (atk_code > `RCD_ATK_MAX) atk_code = `RCD_ATK_MAX;
    dcy_code = timing_ff[`RCD_DCY_F];
    if (dcy_code > `RCD_DCY_MAX) dcy_code = `RCD_DCY_MAX;
    atk_step = 32'(`RCD_STEP(`RCD_ATK_BASE_US)) >> (atk_code - `RCD_ATK_MIN);
    dcy_step = 32'(`RCD_STEP(`RCD_DCY_BASE_US)) >> dcy_code;
    case (timing_ff[`RCD_QRD_F])
      2'b00:   fast_step = 32'(`RCD_STEP(`RCD_QR0_US));
      2'b01:   fast_step = 32'(`RCD_STEP(`RCD_QR1_US));
      default: fast_step = 32'(`RCD_STEP(`RCD_QR2_US));
    endcase
    if (!proc_v) begin
      slew = RCD_HOLD;
    end else if (loud || clip_hit) begin
      slew = RCD_ATTACK;
    end else if (fast_en && crest) begin
      slew = RCD_FAST;
    end else begin
      slew = RCD_DECAY;
    end
    case (slew)
      RCD_ATTACK: step = clip_hit ? atk_step << `RCD_CLIP_BOOST : atk_step;
      RCD_FAST:   step = fast_step;
      RCD_DECAY:  step = dcy_step;
      default:    step = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gain update once per processed sample, clamped to 0dB..-18dB
  always_comb begin
    up       = 32'(gain_ff + step);
    dn       = (gain_ff > step) ? 32'(gain_ff - step) : 32'h00000000;
    nxt_gain = gain_ff;
    nxt_clip = proc_v ? clip_hit : clip_ff;
    case (slew)
      RCD_ATTACK: nxt_gain = (up > `RCD_MAX_ATTEN) ? `RCD_MAX_ATTEN : up;
      RCD_FAST:   nxt_gain = dn;
      RCD_DECAY:  nxt_gain = dn;
      default:    nxt_gain = gain_ff;
    endcase
    if (!en) begin
      nxt_gain = 32'h00000000; // Restart from unity when re-enabled
      nxt_clip = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Two-stage sample pipeline; the other path passes untouched, same latency
  always_comb begin
    nxt_mic_x1 = mic_valid_in ? mic_sample_in : mic_x1_ff;
    nxt_dac_x1 = dac_valid_in ? dac_sample_in : dac_x1_ff;
    nxt_mic_v1 = mic_valid_in;
    nxt_dac_v1 = dac_valid_in;
    nxt_mic_vo = mic_v1_ff;
    nxt_dac_vo = dac_v1_ff;
    nxt_mic_o  = mic_o_ff;
    nxt_dac_o  = dac_o_ff;
    if (mic_v1_ff) nxt_mic_o = (en && !on_dac) ? y : mic_x1_ff;
    if (dac_v1_ff) nxt_dac_o = (en && on_dac) ? y : dac_x1_ff;
    det_v = en & (on_dac ? dac_vo_ff : mic_vo_ff);
    det_x = on_dac ? dac_o_ff : mic_o_ff;
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      mic_x1_ff <= 16'h0000;
      dac_x1_ff <= 16'h0000;
      mic_v1_ff <= 1'b0;
      dac_v1_ff <= 1'b0;
      mic_o_ff  <= 16'h0000;
      dac_o_ff  <= 16'h0000;
      mic_vo_ff <= 1'b0;
      dac_vo_ff <= 1'b0;
      wp_ff     <= 4'h0;
      gain_ff   <= 32'h00000000;
      clip_ff   <= 1'b0;
    end else begin
      mic_x1_ff <= nxt_mic_x1;
      dac_x1_ff <= nxt_dac_x1;
      mic_v1_ff <= nxt_mic_v1;
      dac_v1_ff <= nxt_dac_v1;
      mic_o_ff  <= nxt_mic_o;
      dac_o_ff  <= nxt_dac_o;
      mic_vo_ff <= nxt_mic_vo;
      dac_vo_ff <= nxt_dac_vo;
      wp_ff     <= nxt_wp;
      gain_ff   <= nxt_gain;
      clip_ff   <= nxt_clip;
    end
  end

  // Detector watches the controlled output, closing the feedback loop
  rcd_level_det u_det (
    .clock_in   (clock_in),
    .rstn_in    (rstn_in),
    .valid_in   (det_v),
    .sample_in  (det_x),
    .fast_en_in (fast_en),
    .thr_sel_in (timing_ff[`RCD_THR_F]),
    .loud_out   (loud),
    .crest_out  (crest)
  );

  assign mic_sample_out = mic_o_ff;
  assign mic_valid_out  = mic_vo_ff;
  assign dac_sample_out = dac_o_ff;
  assign dac_valid_out  = dac_vo_ff;
endmodule

// File: design/rcd_level_det.sv
// Level detector: mean square, decaying peak and crest factor flag.
// Assumes one valid pulse per processed output sample, same clock.
`include "rcd_consts.svh"
module rcd_level_det (
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  input  wire logic                 valid_in,
  input  wire rcd_pkg::rcd_sample_t sample_in,
  input  wire logic                 fast_en_in,
  input  wire logic [1:0]           thr_sel_in,
  output logic                      loud_out,
  output logic                      crest_out
);
  import rcd_pkg::*;

  logic [31:0]        ms_ff, nxt_ms, peak_ff, nxt_peak, sq;
  logic signed [32:0] diff;
  logic               loud_ff, nxt_loud, crest_ff, nxt_crest;
  logic [9:0]         k;
  logic [41:0]        ms_k;

  ////////////////////////////////////////////////////////////////////////////////
  // Averaged power, not the raw sample, drives the gain decision
  always_comb begin
    sq        = 32'($signed(sample_in) * $signed(sample_in));
    diff      = $signed({1'b0, sq}) - $signed({1'b0, ms_ff});
    nxt_ms    = ms_ff;
    nxt_peak  = peak_ff;
    nxt_loud  = loud_ff;
    nxt_crest = crest_ff;
    case (thr_sel_in)
      2'b00:   k = `RCD_CREST_K12;
      2'b01:   k = `RCD_CREST_K18;
      2'b10:   k = `RCD_CREST_K24;
      default: k = `RCD_CREST_K30;
    endcase
    ms_k = 42'(ms_ff) * 42'(k); // Power ratio stands in for amplitude ratio
    if (valid_in) begin
      nxt_ms    = 32'(ms_ff + 32'(diff >>> `RCD_MS_SHIFT));
      nxt_peak  = (sq > peak_ff) ? sq : peak_ff - (peak_ff >> `RCD_PEAK_SHIFT);
      nxt_loud  = ms_ff > `RCD_TARGET_MS;
      nxt_crest = fast_en_in && (42'(peak_ff) > ms_k);
    end
    if (!fast_en_in) begin
      nxt_crest = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ms_ff    <= 32'h00000000;
      peak_ff  <= 32'h00000000;
      loud_ff  <= 1'b0;
      crest_ff <= 1'b0;
    end else begin
      ms_ff    <= nxt_ms;
      peak_ff  <= nxt_peak;
      loud_ff  <= nxt_loud;
      crest_ff <= nxt_crest;
    end
  end

  assign loud_out  = loud_ff;
  assign crest_out = crest_ff;
endmodule

// File: inc/rcd_consts.svh
// Named constants for the dynamic range controller dynamics block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef RCD_CONSTS_SVH
`define RCD_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register word indices (byte address is four times the index)
`define RCD_IDX_MAIN        8'h28
`define RCD_IDX_TIMING      8'h29
`define RCD_IDX_STATUS      8'h30
`define RCD_MAIN_RST        16'h00EF
`define RCD_TIMING_RST      16'h3248
`define RCD_LANE0           7:0
`define RCD_LANE1           15:8

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define RCD_EN_BIT          15
`define RCD_PATH_BIT        14
`define RCD_FFDLY_BIT       5
`define RCD_QR_BIT          2
`define RCD_CLIP_BIT        1
`define RCD_ATK_F           15:12
`define RCD_DCY_F           11:8
`define RCD_THR_F           7:6
`define RCD_QRD_F           5:4

////////////////////////////////////////////////////////////////////////////////
// Look-ahead delays in samples and code limits
`define RCD_DLY_SHORT       4'h5
`define RCD_DLY_LONG        4'h9
`define RCD_ATK_MIN         4'h1
`define RCD_ATK_MAX         4'hA
`define RCD_DCY_MAX         4'h8

////////////////////////////////////////////////////////////////////////////////
// Rate times in microseconds per 6dB, sample rate in Hz, 6dB in gain units
`define RCD_FS_HZ           64'h000000000000BB80
`define RCD_US_PER_S        64'h00000000000F4240
`define RCD_LOG_UNIT        64'h0000000001000000
`define RCD_ATK_BASE_US     64'h00000000000000B6
`define RCD_DCY_BASE_US     64'h000000000002D690
`define RCD_QR0_US          64'h00000000000002D5
`define RCD_QR1_US          64'h00000000000005AA
`define RCD_QR2_US          64'h00000000000016A8
// Gain units per sample for a given time per 6dB
`define RCD_STEP(t)         ((`RCD_LOG_UNIT * `RCD_US_PER_S) / ((t) * `RCD_FS_HZ))

////////////////////////////////////////////////////////////////////////////////
// Gain law and level detection
`define RCD_MAX_ATTEN       32'h03000000
`define RCD_UNITY           16'h8000
`define RCD_Q_SHIFT         15
`define RCD_FRAC_DROP       10
`define RCD_CLIP_LEVEL      33'h000007000
`define RCD_CLIP_BOOST      2
`define RCD_TARGET_MS       32'h04000000
`define RCD_MS_SHIFT        8
`define RCD_PEAK_SHIFT      12
`define RCD_CREST_K12       10'h010
`define RCD_CREST_K18       10'h03F
`define RCD_CREST_K24       10'h0FB
`define RCD_CREST_K30       10'h3E8

`endif

// File: inc/rcd_pkg.sv
// Types shared by the dynamic range controller dynamics files.
// Assumes nothing of its surroundings.
package rcd_pkg;
  typedef logic signed [15:0] rcd_sample_t;
  typedef logic [15:0]        rcd_reg_t;
  typedef logic [31:0]        rcd_gain_t;
  typedef enum logic [1:0] {
    RCD_HOLD   = 2'b00,
    RCD_ATTACK = 2'b01,
    RCD_DECAY  = 2'b10,
    RCD_FAST   = 2'b11
  } rcd_slew_t;
endpackage
